// >>> core/pmwc_consts.vh
/*
  constants of the power-mode and wakeup controller: register offsets, field
  positions, reset values and settling counts.
  assumes a byte-wide register port with 8-bit addresses.
*/
`ifndef PMWC_CONSTS_VH
`define PMWC_CONSTS_VH

// register offsets
`define PMWC_OSC_CTRL_ADDR   8'hca
`define PMWC_P1_WAKE_ADDR    8'hc0
`define PMWC_TMR_CTRL_ADDR   8'hc8
`define PMWC_STATUS_ADDR     8'hc9

// oscillator control field positions
`define PMWC_HOSC_STOP_BIT   1
`define PMWC_SLOW_SEL_BIT    2
`define PMWC_OPMODE_LO_BIT   3
`define PMWC_OPMODE_HI_BIT   4

// timer control field positions
`define PMWC_T0_EN_BIT       0
`define PMWC_TC0_EN_BIT      1
`define PMWC_T1_EN_BIT       2

// operating mode codes
`define PMWC_OPMODE_NORMAL   2'b00
`define PMWC_OPMODE_SLEEP    2'b01
`define PMWC_OPMODE_GREEN    2'b10

// reset values
`define PMWC_OSC_CTRL_RST    8'h00
`define PMWC_P1_WAKE_RST     7'h00
`define PMWC_TMR_CTRL_RST    3'h0

// settling after power-down wakeup, in high-oscillator clocks
`define PMWC_SETTLE_CLOCKS   2048

`endif

// >>> core/pmwc_pin_change.v
/*
  pin-change detector: flags a level change on any enabled pin.
  assumes pins are synchronous to clk_i; the reference is refreshed every cycle.
*/
`timescale 1ns/1ps
module pmwc_pin_change #(
  parameter WIDTH = 7
) (
  input  wire             clk_i,
  input  wire             nrst_i,
  input  wire [WIDTH-1:0] pins_i,
  input  wire [WIDTH-1:0] enable_i,
  output wire             change_o
);

  reg  [WIDTH-1:0] last_reg;
  wire [WIDTH-1:0] diff;

  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      last_reg <= {WIDTH{1'b0}};
    else
      last_reg <= pins_i;
  end

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : g_bit
      assign diff[g] = (pins_i[g] ^ last_reg[g]) & enable_i[g];
    end
  endgenerate

  // the first cycle after reset may flag a change; only sleep and green use it
  assign change_o = |diff;

endmodule // pmwc_pin_change

// >>> core/pmwc_ctrl.v
/*
  power-mode and wakeup controller: mode register, port-1 wake mask, timer
  enables, mode sequencer, settling counter, cpu and timer gating.
  assumes a one-cycle register port, pins and timer overflow synchronous to clk_i,
  and the settling count clocked by clk_i standing in for the high oscillator.
*/
`timescale 1ns/1ps
`include "pmwc_consts.vh"
module pmwc_ctrl #(
  parameter SETTLE_CLOCKS = `PMWC_SETTLE_CLOCKS,
  parameter P0_WIDTH      = 4,
  parameter P1_WIDTH      = 7
) (
  input  wire                clk_i,
  input  wire                nrst_i,
  input  wire [7:0]          addr_i,
  input  wire [7:0]          wdata_i,
  input  wire                wr_i,
  input  wire                rd_i,
  output reg  [7:0]          rdata_o,
  input  wire [P0_WIDTH-1:0] port0_i,
  input  wire [P1_WIDTH-1:0] port1_i,
  input  wire                timer0_overflow_i,
  output reg                 cpu_run_o,
  output reg                 slow_clock_select_o,
  output reg                 ext_high_osc_en_o,
  output reg                 ext_low_clock_en_o,
  output reg                 timer0_run_o,
  output reg                 timer_counter0_run_o,
  output reg                 timer1_run_o,
  output reg                 timer_irq_allow_o,
  output reg                 ext_irq_allow_o,
  output reg                 settling_o
);

  ////////////////////////////////////////////////////////////////////////////
  // states and registers

  localparam [3:0] ST_RUN    = 4'b0001;
  localparam [3:0] ST_GREEN  = 4'b0010;
  localparam [3:0] ST_SLEEP  = 4'b0100;
  localparam [3:0] ST_SETTLE = 4'b1000;

  localparam [31:0] SETTLE_LAST_FULL = SETTLE_CLOCKS - 1;
  localparam [11:0] SETTLE_LAST      = SETTLE_LAST_FULL[11:0];

  reg  [3:0]          state_reg;
  reg  [3:0]          state_next;
  reg  [1:0]          op_mode_field_reg;
  reg  [1:0]          op_mode_field_next;
  reg                 slow_clock_select_reg;
  reg                 slow_clock_select_next;
  reg                 high_osc_stop_reg;
  reg                 high_osc_stop_next;
  reg  [P1_WIDTH-1:0] port1_wakeup_mask_reg;
  reg                 timer0_enable_reg;
  reg                 timer_counter0_enable_reg;
  reg                 timer1_enable_reg;
  reg  [11:0]         settle_cnt_reg;
  reg  [11:0]         settle_cnt_next;

  wire osc_wr  = wr_i && (addr_i == `PMWC_OSC_CTRL_ADDR);
  wire p1_wr   = wr_i && (addr_i == `PMWC_P1_WAKE_ADDR);
  wire tmr_wr  = wr_i && (addr_i == `PMWC_TMR_CTRL_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // wakeup detection

  wire p0_change;
  wire p1_change;

  pmwc_pin_change #(.WIDTH(P0_WIDTH)) u_p0_change (
    .clk_i    (clk_i),
    .nrst_i   (nrst_i),
    .pins_i   (port0_i),
    .enable_i ({P0_WIDTH{1'b1}}),
    .change_o (p0_change)
  );

  pmwc_pin_change #(.WIDTH(P1_WIDTH)) u_p1_change (
    .clk_i    (clk_i),
    .nrst_i   (nrst_i),
    .pins_i   (port1_i),
    .enable_i (port1_wakeup_mask_reg),
    .change_o (p1_change)
  );

  wire pin_wake   = p0_change | p1_change;
  wire timer_wake = timer0_enable_reg & timer0_overflow_i;

  ////////////////////////////////////////////////////////////////////////////
  // mode sequencer

  always @*
  begin
    state_next             = state_reg;
    op_mode_field_next     = op_mode_field_reg;
    slow_clock_select_next = slow_clock_select_reg;
    high_osc_stop_next     = high_osc_stop_reg;
    settle_cnt_next        = settle_cnt_reg;
    case (state_reg)
      ST_RUN:
      begin
        if (osc_wr)
        begin
          // clock select applies at once, both directions
          slow_clock_select_next = wdata_i[`PMWC_SLOW_SEL_BIT];
          high_osc_stop_next     = wdata_i[`PMWC_HOSC_STOP_BIT];
          op_mode_field_next     = wdata_i[`PMWC_OPMODE_HI_BIT:`PMWC_OPMODE_LO_BIT];
          if (op_mode_field_next == `PMWC_OPMODE_SLEEP)
            state_next = ST_SLEEP;
          else if (op_mode_field_next == `PMWC_OPMODE_GREEN)
            state_next = ST_GREEN;
          else
            op_mode_field_next = `PMWC_OPMODE_NORMAL; // reserved 11 treated as normal
        end
      end
      ST_GREEN:
      begin
        if (pin_wake || timer_wake)
        begin
          state_next         = ST_RUN;
          op_mode_field_next = `PMWC_OPMODE_NORMAL;
        end
      end
      ST_SLEEP:
      begin
        if (pin_wake)
        begin
          state_next      = ST_SETTLE;
          settle_cnt_next = 12'h000;
          // restart the high oscillator: settling counts its clocks
          high_osc_stop_next = 1'b0;
        end
      end
      ST_SETTLE:
      begin
        if (settle_cnt_reg == SETTLE_LAST)
        begin
          state_next             = ST_RUN;
          op_mode_field_next     = `PMWC_OPMODE_NORMAL;
          slow_clock_select_next = 1'b0;
          high_osc_stop_next     = 1'b0;
        end
        else
          settle_cnt_next = settle_cnt_reg + 12'h001;
      end
      default:
        state_next = ST_RUN;
    endcase
  end

  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_reg                 <= ST_RUN;
      op_mode_field_reg         <= `PMWC_OPMODE_NORMAL;
      slow_clock_select_reg     <= 1'b0;
      high_osc_stop_reg         <= 1'b0;
      settle_cnt_reg            <= 12'h000;
      port1_wakeup_mask_reg     <= `PMWC_P1_WAKE_RST;
      timer0_enable_reg         <= 1'b0;
      timer_counter0_enable_reg <= 1'b0;
      timer1_enable_reg         <= 1'b0;
    end
    else
    begin
      state_reg             <= state_next;
      op_mode_field_reg     <= op_mode_field_next;
      slow_clock_select_reg <= slow_clock_select_next;
      high_osc_stop_reg     <= high_osc_stop_next;
      settle_cnt_reg        <= settle_cnt_next;
      if (p1_wr)
        port1_wakeup_mask_reg <= wdata_i[P1_WIDTH-1:0];
      if (tmr_wr)
      begin
        timer0_enable_reg         <= wdata_i[`PMWC_T0_EN_BIT];
        timer_counter0_enable_reg <= wdata_i[`PMWC_TC0_EN_BIT];
        timer1_enable_reg         <= wdata_i[`PMWC_T1_EN_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, registered from the next-state view so they track the state

  wire next_run    = (state_next == ST_RUN);
  wire next_green  = (state_next == ST_GREEN);
  wire next_sleep  = (state_next == ST_SLEEP);
  wire next_active = next_run | next_green;

  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cpu_run_o            <= 1'b1;
      slow_clock_select_o  <= 1'b0;
      ext_high_osc_en_o    <= 1'b1;
      ext_low_clock_en_o   <= 1'b1;
      timer0_run_o         <= 1'b0;
      timer_counter0_run_o <= 1'b0;
      timer1_run_o         <= 1'b0;
      timer_irq_allow_o    <= 1'b1;
      ext_irq_allow_o      <= 1'b1;
      settling_o           <= 1'b0;
      rdata_o              <= 8'h00;
    end
    else
    begin
      cpu_run_o            <= next_run;
      slow_clock_select_o  <= slow_clock_select_next;
      ext_high_osc_en_o    <= !next_sleep && !high_osc_stop_next;
      ext_low_clock_en_o   <= !next_sleep;
      timer0_run_o         <= next_active && timer0_enable_reg;
      timer_counter0_run_o <= next_active && timer_counter0_enable_reg;
      timer1_run_o         <= next_active && timer1_enable_reg;
      timer_irq_allow_o    <= next_active;
      ext_irq_allow_o      <= next_active;
      settling_o           <= (state_next == ST_SETTLE);
      // mask register is write-only and reads as zero
      if (rd_i && addr_i == `PMWC_OSC_CTRL_ADDR)
        rdata_o <= {3'h0, op_mode_field_reg, slow_clock_select_reg,
                    high_osc_stop_reg, 1'b0};
      else if (rd_i && addr_i == `PMWC_TMR_CTRL_ADDR)
        rdata_o <= {5'h00, timer1_enable_reg, timer_counter0_enable_reg,
                    timer0_enable_reg};
      else if (rd_i && addr_i == `PMWC_STATUS_ADDR)
        rdata_o <= {4'h0, state_reg};
      else
        rdata_o <= 8'h00;
    end
  end

endmodule // pmwc_ctrl

// >>> verification/pmwc_ctrl_props.sv
/*
  checker for the mode sequencer, watching only the controller's ports.
  assumes one clock, active-low async reset, bound to pmwc_ctrl.
*/
`timescale 1ns/1ps
module pmwc_ctrl_props #(
  parameter SETTLE_CLOCKS = 2048
) (
  input wire       clk_i,
  input wire       nrst_i,
  input wire [7:0] addr_i,
  input wire       rd_i,
  input wire [7:0] rdata_o,
  input wire [3:0] port0_i,
  input wire [6:0] port1_i,
  input wire       timer0_overflow_i,
  input wire       cpu_run_o,
  input wire       slow_clock_select_o,
  input wire       ext_high_osc_en_o,
  input wire       ext_low_clock_en_o,
  input wire       timer0_run_o,
  input wire       timer_counter0_run_o,
  input wire       timer1_run_o,
  input wire       timer_irq_allow_o,
  input wire       ext_irq_allow_o,
  input wire       settling_o
);
  reg  [15:0] settle_cnt_reg;
  wire        green = !cpu_run_o && ext_low_clock_en_o && !settling_o;
  wire        asleep = !ext_low_clock_en_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // counts settling cycles; a counter because the span is far too long to unroll
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      settle_cnt_reg <= 16'h0000;
    else
      settle_cnt_reg <= settling_o ? settle_cnt_reg + 16'h0001 : 16'h0000;
  end
  ////////////////////////////////////////////////////////////////////////////
  settle_len_a: assert property ($fell(settling_o) |-> settle_cnt_reg == SETTLE_CLOCKS)
    else $error("settling span wrong");
  settle_end_a: assert property ($fell(settling_o) |->
    cpu_run_o && !slow_clock_select_o && ext_high_osc_en_o)
    else $error("settle did not end in normal mode");
  settle_halt_a: assert property (settling_o |-> !cpu_run_o)
    else $error("cpu ran while settling");
  settle_osc_a: assert property (settling_o |-> ext_high_osc_en_o)
    else $error("high oscillator off while settling");
  sleep_osc_a: assert property (asleep |-> !ext_high_osc_en_o && !cpu_run_o)
    else $error("oscillator or cpu alive in sleep");
  sleep_quiet_a: assert property (asleep |-> !(timer0_run_o || timer_counter0_run_o ||
    timer1_run_o || timer_irq_allow_o || ext_irq_allow_o))
    else $error("timer or interrupt alive in sleep");
  mask_read_a: assert property (rd_i && addr_i == 8'hc0 |=> rdata_o == 8'h00)
    else $error("wake mask readable");
  t0_wake_a: assert property (green && timer0_run_o && timer0_overflow_i |=> cpu_run_o)
    else $error("timer overflow missed in green");
  t0_off_a: assert property (green && !timer0_run_o && timer0_overflow_i &&
    $stable(port0_i) && $stable(port1_i) |=> !cpu_run_o)
    else $error("disabled timer woke green");
  sleep_t0_a: assert property (asleep && timer0_overflow_i &&
    $stable(port0_i) && $stable(port1_i) |=> !settling_o)
    else $error("timer overflow woke sleep");
  green_slow_a: assert property (green |=> $stable(slow_clock_select_o))
    else $error("clock select moved in green");
endmodule // pmwc_ctrl_props
bind pmwc_ctrl pmwc_ctrl_props #(.SETTLE_CLOCKS(SETTLE_CLOCKS)) u_props (
  .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .port0_i(port0_i), .port1_i(port1_i), .timer0_overflow_i(timer0_overflow_i),
  .cpu_run_o(cpu_run_o), .slow_clock_select_o(slow_clock_select_o),
  .ext_high_osc_en_o(ext_high_osc_en_o), .ext_low_clock_en_o(ext_low_clock_en_o),
  .timer0_run_o(timer0_run_o), .timer_counter0_run_o(timer_counter0_run_o),
  .timer1_run_o(timer1_run_o), .timer_irq_allow_o(timer_irq_allow_o),
  .ext_irq_allow_o(ext_irq_allow_o), .settling_o(settling_o));

// >>> verification/pmwc_pin_model.sv
/*
  far side: port pins that toggle on request and a timer overflow pulse.
  assumes requests come one cycle long, synchronous to clk_i.
*/
`timescale 1ns/1ps
module pmwc_pin_model (
  input  wire       clk_i,
  input  wire       nrst_i,
  input  wire [3:0] p0_flip_i,
  input  wire [6:0] p1_flip_i,
  input  wire       ovf_req_i,
  output reg  [3:0] port0_o,
  output reg  [6:0] port1_o,
  output reg        timer0_overflow_o
);
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      port0_o <= 4'hf;
      port1_o <= 7'h00;
      timer0_overflow_o <= 1'b0;
    end
    else
    begin
      port0_o <= port0_o ^ p0_flip_i;
      port1_o <= port1_o ^ p1_flip_i;
      timer0_overflow_o <= ovf_req_i;
    end
  end
endmodule // pmwc_pin_model

// >>> verification/power_mode_wakeup_ctrl_test.sv
/*
  testbench: register port master, pin model, read checks through a queue.
  assumes a one-cycle register port and a short settling parameter.
*/
`timescale 1ns/1ps
`include "pmwc_consts.vh"
`define PMWC_CHK(n, e, s) \
  tests_run++; \
  if ((s) !== (e)) begin num_errors++; $display("BAD %s exp %h got %h", n, e, s); end
module power_mode_wakeup_ctrl_test;
  localparam SETTLE = 8;
  reg         clk_i = 1'b0;
  reg         nrst_i = 1'b0;
  reg  [7:0]  addr_i = 8'h00;
  reg  [7:0]  wdata_i = 8'h00;
  reg         wr_i = 1'b0;
  reg         rd_i = 1'b0;
  reg  [3:0]  p0_flip = 4'h0;
  reg  [6:0]  p1_flip = 7'h00;
  reg         ovf_req = 1'b0;
  reg         rd_seen = 1'b0;
  reg  [31:0] rnd = 32'h57da;
  logic [7:0] exp_q[$];
  int         num_errors = 0;
  int         tests_run = 0;
  wire [7:0]  rdata_o;
  wire [3:0]  port0;
  wire [6:0]  port1;
  wire        ovf, cpu_run, slow, hosc, lclk, t0r, tc0r, t1r, tirq, eirq, settle;
  always #12.5 clk_i = ~clk_i;
  pmwc_pin_model u_pins (.clk_i(clk_i), .nrst_i(nrst_i), .p0_flip_i(p0_flip),
    .p1_flip_i(p1_flip), .ovf_req_i(ovf_req), .port0_o(port0), .port1_o(port1),
    .timer0_overflow_o(ovf));
  pmwc_ctrl #(.SETTLE_CLOCKS(SETTLE)) dut (.clk_i(clk_i), .nrst_i(nrst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .port0_i(port0), .port1_i(port1), .timer0_overflow_i(ovf), .cpu_run_o(cpu_run),
    .slow_clock_select_o(slow), .ext_high_osc_en_o(hosc), .ext_low_clock_en_o(lclk),
    .timer0_run_o(t0r), .timer_counter0_run_o(tc0r), .timer1_run_o(t1r),
    .timer_irq_allow_o(tirq), .ext_irq_allow_o(eirq), .settling_o(settle));
  ////////////////////////////////////////////////////////////////////////////
  function [31:0] xs(input [31:0] s);
    xs = s ^ (s << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  task wrap_up;
    if (num_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    exp_q.push_back(e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
  endtask
  // the two idle cycles let a mode change land before status is read
  task st(input [7:0] e);
    repeat (2) @(posedge clk_i);
    rd(`PMWC_STATUS_ADDR, e);
  endtask
  task pin(input [3:0] f0, input [6:0] f1, input o);
    @(posedge clk_i);
    p0_flip <= f0;
    p1_flip <= f1;
    ovf_req <= o;
    @(posedge clk_i);
    p0_flip <= 4'h0;
    p1_flip <= 7'h00;
    ovf_req <= 1'b0;
  endtask
  always @(posedge clk_i)
  begin
    if (rd_seen)
    begin
      `PMWC_CHK("rdata_o", exp_q.pop_front(), rdata_o)
    end
    rd_seen <= rd_i;
  end
  initial
  begin
    #(25 * 4000);
    num_errors++;
    wrap_up;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    #1;
    `PMWC_CHK("slow", 1'b0, slow)
    st(8'h01);
    rd(`PMWC_P1_WAKE_ADDR, 8'h00);
    rnd = xs(rnd);
    rd({1'b0, rnd[6:0]}, 8'h00);
    wr(`PMWC_OSC_CTRL_ADDR, 8'h18);
    st(8'h01);
    rd(`PMWC_OSC_CTRL_ADDR, 8'h00);
    wr(`PMWC_TMR_CTRL_ADDR, 8'h07);
    rd(`PMWC_TMR_CTRL_ADDR, 8'h07);
    wr(`PMWC_OSC_CTRL_ADDR, 8'h04);
    st(8'h01);
    `PMWC_CHK("slow", 1'b1, slow)
    `PMWC_CHK("timers", 3'h7, {t0r, tc0r, t1r})
    wr(`PMWC_OSC_CTRL_ADDR, 8'h06);
    st(8'h01);
    rd(`PMWC_OSC_CTRL_ADDR, 8'h06);
    `PMWC_CHK("osc", 2'b01, {hosc, lclk})
    wr(`PMWC_OSC_CTRL_ADDR, 8'h04);
    repeat (8) @(posedge clk_i);
    wr(`PMWC_OSC_CTRL_ADDR, 8'h00);
    st(8'h01);
    `PMWC_CHK("slow", 1'b0, slow)
    wr(`PMWC_TMR_CTRL_ADDR, 8'h00);
    wr(`PMWC_OSC_CTRL_ADDR, 8'h14);
    st(8'h02);
    `PMWC_CHK("cpu_run", 1'b0, cpu_run)
    `PMWC_CHK("green_irq", 2'b11, {tirq, eirq})
    // a mode write while halted is refused, the block stays green
    wr(`PMWC_OSC_CTRL_ADDR, 8'h00);
    st(8'h02);
    pin(4'h0, 7'h00, 1'b1);
    st(8'h02);
    pin(4'h1, 7'h00, 1'b0);
    st(8'h01);
    `PMWC_CHK("slow", 1'b1, slow)
    wr(`PMWC_TMR_CTRL_ADDR, 8'h01);
    wr(`PMWC_OSC_CTRL_ADDR, 8'h10);
    pin(4'h0, 7'h00, 1'b1);
    st(8'h01);
    wr(`PMWC_P1_WAKE_ADDR, 8'h01);
    rd(`PMWC_P1_WAKE_ADDR, 8'h00);
    // sleep with the high-oscillator stop bit set: settling must restart it
    wr(`PMWC_OSC_CTRL_ADDR, 8'h0a);
    st(8'h04);
    `PMWC_CHK("sleep", 5'h00, {hosc, lclk, t0r, tc0r, t1r})
    `PMWC_CHK("sleep_irq", 2'b00, {tirq, eirq})
    rnd = xs(rnd);
    pin(4'h0, 7'h01 << (1 + rnd % 6), 1'b0);
    st(8'h04);
    pin(4'h0, 7'h00, 1'b1);
    st(8'h04);
    pin(4'h0, 7'h01, 1'b0);
    st(8'h08);
    `PMWC_CHK("settle", 1'b1, settle)
    `PMWC_CHK("settle_hosc", 1'b1, hosc)
    repeat (SETTLE) @(posedge clk_i);
    st(8'h01);
    `PMWC_CHK("slow_hosc", 2'b01, {slow, hosc})
    `PMWC_CHK("settle_end", 1'b0, settle)
    repeat (2) @(posedge clk_i);
    wrap_up;
  end
endmodule // power_mode_wakeup_ctrl_test
